// File: rtl/ssm_map.svh
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH

// Direct address window of the special register space
`define SSM_SPACE_BASE 8'h80
`define SSM_SPACE_TOP_BIT 7
`define SSM_INDEX_W 7
`define SSM_SPACE_DEPTH 128

// Register offsets
`define SSM_ADDR_PORT0_LATCH 8'h80
`define SSM_ADDR_STACK_POINTER 8'h81
`define SSM_ADDR_DATA_POINTER_LOW 8'h82
`define SSM_ADDR_DATA_POINTER_HIGH 8'h83
`define SSM_ADDR_POWER_CONTROL 8'h87
`define SSM_ADDR_TIMER_CONTROL 8'h88
`define SSM_ADDR_TIMER_MODE_SELECT 8'h89
`define SSM_ADDR_TIMER0_LOW_COUNT 8'h8A
`define SSM_ADDR_TIMER1_LOW_COUNT 8'h8B
`define SSM_ADDR_TIMER0_HIGH_COUNT 8'h8C
`define SSM_ADDR_TIMER1_HIGH_COUNT 8'h8D
`define SSM_ADDR_PORT1_LATCH 8'h90
`define SSM_ADDR_PORT0_CONFIG_A 8'h96
`define SSM_ADDR_PORT0_CONFIG_B 8'h97
`define SSM_ADDR_ADC_LOW_BITS_COMPARE 8'h98
`define SSM_ADDR_PORT1_CONFIG_A 8'h9E
`define SSM_ADDR_PORT1_CONFIG_B 8'h9F
`define SSM_ADDR_PORT2_LATCH 8'hA0
`define SSM_ADDR_PORT2_CONFIG_A 8'hA6
`define SSM_ADDR_PORT2_CONFIG_B 8'hA7
`define SSM_ADDR_INTERRUPT_ENABLE 8'hA8
`define SSM_ADDR_PORT3_LATCH 8'hB0
`define SSM_ADDR_CHAR_BANK_SELECT 8'hB2
`define SSM_ADDR_TWIN_COLOUR_SELECT 8'hB3
`define SSM_ADDR_OSD_LANGUAGE_SELECT 8'hB4
`define SSM_ADDR_DISPLAY_SIZE_PORT_SELECT 8'hB5
`define SSM_ADDR_GENERAL_PURPOSE_FLAGS 8'hB6
`define SSM_ADDR_CAPTION_SLICE_LINE 8'hB7
`define SSM_ADDR_INTERRUPT_PRIORITY 8'hB8
`define SSM_ADDR_FORCE_MODE_SCREEN_COLOUR 8'hB9
`define SSM_ADDR_PORT3_CONFIG_A 8'hBE
`define SSM_ADDR_PORT3_CONFIG_B 8'hBF
`define SSM_ADDR_FRAME_OUTPUT_CONTROL 8'hC0
`define SSM_ADDR_SYNC_POLARITY_CONTROL 8'hC1
`define SSM_ADDR_DISPLAY_FEATURE_ENABLE 8'hC4
`define SSM_ADDR_PICTURE_MIX_CONTROL_A 8'hC5
`define SSM_ADDR_PICTURE_MIX_CONTROL_B 8'hC6
`define SSM_ADDR_BOX_CURSOR_CONTROL 8'hC7
`define SSM_ADDR_ACQUISITION_CONTROL_STATUS 8'hC8
`define SSM_ADDR_CURSOR_ROW_CLEAR 8'hC9
`define SSM_ADDR_CURSOR_COLUMN 8'hCA
`define SSM_ADDR_DISPLAY_MEMORY_DATA 8'hCB
`define SSM_ADDR_VIDEO_STATUS_VERSION 8'hCC
`define SSM_ADDR_PROGRAM_STATUS_WORD 8'hD0
`define SSM_ADDR_TUNING_DAC_LOW 8'hD2
`define SSM_ADDR_TUNING_DAC_HIGH 8'hD3

// Reset values, zero included
`define SSM_RST_ZERO 8'h00
`define SSM_RST_ONES 8'hFF
`define SSM_RST_STACK_POINTER 8'h07
`define SSM_RST_DISPLAY_SIZE 8'h02
`define SSM_RST_CAPTION_SLICE 8'h15
`define SSM_RST_PICTURE_MIX 8'h03
`define SSM_RST_TUNING_DAC_HIGH 8'h40

// Writable bit masks; clear bits are reserved or fixed
`define SSM_MASK_FULL 8'hFF
`define SSM_MASK_NONE 8'h00
`define SSM_MASK_POWER_CONTROL 8'h7F
`define SSM_MASK_ADC_LOW_BITS 8'h1F
`define SSM_MASK_CHAR_BANK 8'hF3
`define SSM_MASK_TWIN_COLOUR 8'hF3
`define SSM_MASK_OSD_LANGUAGE 8'hCF
`define SSM_MASK_CAPTION_SLICE 8'h1F
`define SSM_MASK_INTERRUPT_PRIORITY 8'h7F
`define SSM_MASK_FORCE_MODE 8'h7F
`define SSM_MASK_FRAME_OUTPUT 8'h24
`define SSM_MASK_SYNC_POLARITY 8'h07
`define SSM_MASK_BOX_CURSOR 8'h4F
`define SSM_MASK_ACQUISITION 8'h5F
`define SSM_MASK_CURSOR_ROW 8'hDF
`define SSM_MASK_CURSOR_COLUMN 8'h3F
`define SSM_MASK_TUNING_DAC_HIGH 8'hBF

// Bits that read as constant one
`define SSM_ONES_NONE 8'h00
`define SSM_ONES_TUNING_DAC_HIGH 8'h40

// Field positions
`define SSM_LANG_SEL_MSB 2
`define SSM_LANG_ENABLE_BIT 3
`define SSM_LANG_PLANES_BIT 6
`define SSM_LANG_REDEF_BIT 7
`define SSM_SIZE_LINES_MSB 7
`define SSM_SIZE_LINES_LSB 6
`define SSM_SIZE_CHAR_MSB 5
`define SSM_SIZE_CHAR_LSB 4
`define SSM_SIZE_PORT1_BIT 3
`define SSM_SIZE_CAPTION_BIT 2
`define SSM_SIZE_PORT0_BIT 1
`define SSM_SIZE_MODE_BIT 0
`define SSM_SYNC_FIELD_BIT 2
`define SSM_SYNC_H_BIT 1
`define SSM_SYNC_V_BIT 0
`define SSM_VIDEO_ONE_BIT 1'b1

`endif

// File: rtl/ssm_pkg.sv
package ssm_pkg;

    typedef logic [7:0] ssm_byte_t;

    // Decoded properties of one direct address
    typedef struct packed {
        logic impl;
        logic ro;
        ssm_byte_t rst;
        ssm_byte_t wmask;
        ssm_byte_t ones;
    } ssm_info_s;

    // Kind of access presented by the core
    typedef enum logic [1:0] {
        SSM_ACC_NONE,
        SSM_ACC_BYTE,
        SSM_ACC_BIT
    } ssm_acc_e;

endpackage : ssm_pkg

// File: rtl/ssm_sfr_space.sv
// Behaviour
// - Only direct-addressed accesses reach these registers; indirect ones are ignored.
// - Registers at addresses ending in 0H or 8H allow single-bit reads and writes too.
// - Port configuration A registers reset to all ones and B registers to all zeros.
// - The language register holds selection, enable, planes and redefinable enable, reset 0.
// - The video status register reports sync standard, ROM version, a one and quality.
// - The display feature register holds eight enables from bank down to shadow, reset 0.
// - The display size register holds lines, size, port selects and caption bits, reset 02H.
// - The sync polarity register selects field, H and V polarity in bits 2 to 0, reset 0.
// - The space covers direct addresses 80H to FFH, apart from lower data memory.
`include "ssm_map.svh"
`timescale 1ns/1ns
`default_nettype none

module ssm_sfr_space #(
    parameter logic [4:0] ROM_VERSION = 5'h01 // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic acc_direct,
    input wire logic acc_bit,
    input wire logic acc_rd,
    input wire logic acc_wr,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic [7:0] gpf_in,
    input wire logic sync_525,
    input wire logic signal_quality_flag,
    output logic [7:0] rd_data,
    output logic rd_hit,
    output logic [7:0] port0_config_a,
    output logic [7:0] port0_config_b,
    output logic [7:0] port1_config_a,
    output logic [7:0] port1_config_b,
    output logic [7:0] port2_config_a,
    output logic [7:0] port2_config_b,
    output logic [7:0] port3_config_a,
    output logic [7:0] port3_config_b,
    output logic [2:0] language_sel,
    output logic language_enable,
    output logic planes_bit,
    output logic redefinable_char_enable,
    output logic [7:0] display_feature_enable,
    output logic [1:0] display_line_count,
    output logic [1:0] character_size,
    output logic bus_port1_select,
    output logic bus_port0_select,
    output logic caption_enable,
    output logic caption_or_teletext_mode,
    output logic field_polarity,
    output logic h_polarity,
    output logic v_polarity
);

    // Elaboration guard: the version field is five bits by layout
    if ($bits(ROM_VERSION) != 5) begin : g_bad_version
        $error("ROM_VERSION must be five bits wide");
    end

    // Builds one address descriptor
    function automatic ssm_pkg::ssm_info_s mk(input logic ro_flag,
                                              input ssm_pkg::ssm_byte_t rst_v,
                                              input ssm_pkg::ssm_byte_t mask_v,
                                              input ssm_pkg::ssm_byte_t ones_v);
        ssm_pkg::ssm_info_s r;
        r.impl = 1'b1;
        r.ro = ro_flag;
        r.rst = rst_v & mask_v;
        r.wmask = mask_v;
        r.ones = ones_v;
        return r;
    endfunction : mk

    // Address decode of the whole space; unlisted addresses stay unimplemented
    function automatic ssm_pkg::ssm_info_s info_of(input logic [7:0] a);
        ssm_pkg::ssm_info_s i;
        i = '0;
        if (a == `SSM_ADDR_PORT0_LATCH || a == `SSM_ADDR_PORT1_LATCH ||
            a == `SSM_ADDR_PORT2_LATCH || a == `SSM_ADDR_PORT3_LATCH) begin
            i = mk(1'b0, `SSM_RST_ONES, `SSM_MASK_FULL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_STACK_POINTER) begin
            i = mk(1'b0, `SSM_RST_STACK_POINTER, `SSM_MASK_FULL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_DATA_POINTER_LOW || a == `SSM_ADDR_DATA_POINTER_HIGH ||
                     a == `SSM_ADDR_TIMER_CONTROL || a == `SSM_ADDR_TIMER_MODE_SELECT ||
                     a == `SSM_ADDR_TIMER0_LOW_COUNT || a == `SSM_ADDR_TIMER1_LOW_COUNT ||
                     a == `SSM_ADDR_TIMER0_HIGH_COUNT || a == `SSM_ADDR_TIMER1_HIGH_COUNT ||
                     a == `SSM_ADDR_INTERRUPT_ENABLE || a == `SSM_ADDR_DISPLAY_MEMORY_DATA ||
                     a == `SSM_ADDR_PROGRAM_STATUS_WORD || a == `SSM_ADDR_TUNING_DAC_LOW) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_FULL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_PORT0_CONFIG_A || a == `SSM_ADDR_PORT1_CONFIG_A ||
                     a == `SSM_ADDR_PORT2_CONFIG_A || a == `SSM_ADDR_PORT3_CONFIG_A) begin
            i = mk(1'b0, `SSM_RST_ONES, `SSM_MASK_FULL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_PORT0_CONFIG_B || a == `SSM_ADDR_PORT1_CONFIG_B ||
                     a == `SSM_ADDR_PORT2_CONFIG_B || a == `SSM_ADDR_PORT3_CONFIG_B) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_FULL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_POWER_CONTROL) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_POWER_CONTROL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_ADC_LOW_BITS_COMPARE) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_ADC_LOW_BITS, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_CHAR_BANK_SELECT) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_CHAR_BANK, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_TWIN_COLOUR_SELECT) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_TWIN_COLOUR, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_OSD_LANGUAGE_SELECT) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_OSD_LANGUAGE, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_DISPLAY_SIZE_PORT_SELECT) begin
            i = mk(1'b0, `SSM_RST_DISPLAY_SIZE, `SSM_MASK_FULL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_GENERAL_PURPOSE_FLAGS ||
                     a == `SSM_ADDR_VIDEO_STATUS_VERSION) begin
            i = mk(1'b1, `SSM_RST_ZERO, `SSM_MASK_NONE, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_CAPTION_SLICE_LINE) begin
            i = mk(1'b0, `SSM_RST_CAPTION_SLICE, `SSM_MASK_CAPTION_SLICE, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_INTERRUPT_PRIORITY) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_INTERRUPT_PRIORITY, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_FORCE_MODE_SCREEN_COLOUR) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_FORCE_MODE, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_FRAME_OUTPUT_CONTROL) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_FRAME_OUTPUT, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_SYNC_POLARITY_CONTROL) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_SYNC_POLARITY, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_DISPLAY_FEATURE_ENABLE) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_FULL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_PICTURE_MIX_CONTROL_A ||
                     a == `SSM_ADDR_PICTURE_MIX_CONTROL_B) begin
            i = mk(1'b0, `SSM_RST_PICTURE_MIX, `SSM_MASK_FULL, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_BOX_CURSOR_CONTROL) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_BOX_CURSOR, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_ACQUISITION_CONTROL_STATUS) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_ACQUISITION, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_CURSOR_ROW_CLEAR) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_CURSOR_ROW, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_CURSOR_COLUMN) begin
            i = mk(1'b0, `SSM_RST_ZERO, `SSM_MASK_CURSOR_COLUMN, `SSM_ONES_NONE);
        end else if (a == `SSM_ADDR_TUNING_DAC_HIGH) begin
            i = mk(1'b0, `SSM_RST_TUNING_DAC_HIGH, `SSM_MASK_TUNING_DAC_HIGH,
                   `SSM_ONES_TUNING_DAC_HIGH);
        end
        return i;
    endfunction : info_of

    // Reset value of one address, kept apart so no select follows a call
    function automatic ssm_pkg::ssm_byte_t rst_of(input logic [7:0] a);
        ssm_pkg::ssm_info_s i;
        i = info_of(a);
        return i.rst;
    endfunction : rst_of

    // Storage: one byte per address of the upper half, writable bits only
    ssm_pkg::ssm_byte_t regs_q [0:`SSM_SPACE_DEPTH-1];
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic rd_hit_q;
    logic rd_hit_d;

    // Bit addresses name the aligned register in the top five bits
    wire ssm_pkg::ssm_acc_e acc_kind = !acc_direct ? ssm_pkg::SSM_ACC_NONE :
                                       acc_bit ? ssm_pkg::SSM_ACC_BIT :
                                       ssm_pkg::SSM_ACC_BYTE;
    wire logic [7:0] bit_reg_addr = {acc_addr[7:3], 3'h0};
    wire logic [2:0] bit_pos = acc_addr[2:0];
    wire logic [7:0] reg_addr = (acc_kind == ssm_pkg::SSM_ACC_BIT) ? bit_reg_addr : acc_addr;
    // Lower half belongs to data memory, so only bit 7 set selects this space
    wire logic in_space = acc_addr[`SSM_SPACE_TOP_BIT];
    wire logic selected = (acc_kind != ssm_pkg::SSM_ACC_NONE) && in_space;
    wire ssm_pkg::ssm_info_s cur_info = info_of(reg_addr);
    wire logic hit = selected && cur_info.impl;
    wire logic [`SSM_INDEX_W-1:0] idx = reg_addr[`SSM_INDEX_W-1:0];

    // Live value seen by the core, status registers built from inputs
    wire logic [7:0] video_status = {sync_525, ROM_VERSION, `SSM_VIDEO_ONE_BIT,
                                     signal_quality_flag};
    wire logic [7:0] view_byte =
        (reg_addr == `SSM_ADDR_GENERAL_PURPOSE_FLAGS) ? gpf_in :
        (reg_addr == `SSM_ADDR_VIDEO_STATUS_VERSION) ? video_status :
        ((regs_q[idx] & cur_info.wmask) | cur_info.ones);

    // Merge for a write; a bit write is a read-modify-write of one bit
    wire logic [7:0] bit_onehot = 8'h01 << bit_pos;
    wire logic [7:0] bit_merge = acc_wdata[0] ? (regs_q[idx] | bit_onehot) :
                                                (regs_q[idx] & ~bit_onehot);
    wire logic [7:0] merged = (acc_kind == ssm_pkg::SSM_ACC_BIT) ? bit_merge : acc_wdata;
    wire logic wr_en = hit && acc_wr && !cur_info.ro;
    wire logic [7:0] wr_value = merged & cur_info.wmask;

    // Register array; reset loads the documented values
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            for (int k = 0; k < `SSM_SPACE_DEPTH; k++) begin
                regs_q[k] <= rst_of(`SSM_SPACE_BASE | 8'(k));
            end
        end else if (wr_en) begin
            regs_q[idx] <= wr_value;
        end
    end

    // Read answer, registered; a bit read returns the bit in lane 0
    always_comb begin
        rd_data_d = 8'h00;
        rd_hit_d = 1'b0;
        if (hit && acc_rd) begin
            rd_hit_d = 1'b1;
            if (acc_kind == ssm_pkg::SSM_ACC_BIT) begin
                rd_data_d = {7'h00, view_byte[bit_pos]};
            end else begin
                rd_data_d = view_byte;
            end
        end
    end

    // Answer flops; a miss or indirect access reads zero
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rd_data_q <= 8'h00;
            rd_hit_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_hit_q <= rd_hit_d;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_hit = rd_hit_q;

    // Port configuration pairs towards the pad logic
    assign port0_config_a = regs_q[7'(`SSM_ADDR_PORT0_CONFIG_A)];
    assign port0_config_b = regs_q[7'(`SSM_ADDR_PORT0_CONFIG_B)];
    assign port1_config_a = regs_q[7'(`SSM_ADDR_PORT1_CONFIG_A)];
    assign port1_config_b = regs_q[7'(`SSM_ADDR_PORT1_CONFIG_B)];
    assign port2_config_a = regs_q[7'(`SSM_ADDR_PORT2_CONFIG_A)];
    assign port2_config_b = regs_q[7'(`SSM_ADDR_PORT2_CONFIG_B)];
    assign port3_config_a = regs_q[7'(`SSM_ADDR_PORT3_CONFIG_A)];
    assign port3_config_b = regs_q[7'(`SSM_ADDR_PORT3_CONFIG_B)];

    // Language selection fields
    wire logic [7:0] lang_q = regs_q[7'(`SSM_ADDR_OSD_LANGUAGE_SELECT)];
    assign language_sel = lang_q[`SSM_LANG_SEL_MSB:0];
    assign language_enable = lang_q[`SSM_LANG_ENABLE_BIT];
    assign planes_bit = lang_q[`SSM_LANG_PLANES_BIT];
    assign redefinable_char_enable = lang_q[`SSM_LANG_REDEF_BIT];

    // Display feature enables, bank in bit 7 down to shadow in bit 0
    assign display_feature_enable = regs_q[7'(`SSM_ADDR_DISPLAY_FEATURE_ENABLE)];

    // Display size and bus port selection fields
    wire logic [7:0] size_q = regs_q[7'(`SSM_ADDR_DISPLAY_SIZE_PORT_SELECT)];
    assign display_line_count = size_q[`SSM_SIZE_LINES_MSB:`SSM_SIZE_LINES_LSB];
    assign character_size = size_q[`SSM_SIZE_CHAR_MSB:`SSM_SIZE_CHAR_LSB];
    assign bus_port1_select = size_q[`SSM_SIZE_PORT1_BIT];
    assign caption_enable = size_q[`SSM_SIZE_CAPTION_BIT];
    assign bus_port0_select = size_q[`SSM_SIZE_PORT0_BIT];
    assign caption_or_teletext_mode = size_q[`SSM_SIZE_MODE_BIT];

    // Sync polarity selects
    wire logic [7:0] sync_q = regs_q[7'(`SSM_ADDR_SYNC_POLARITY_CONTROL)];
    assign field_polarity = sync_q[`SSM_SYNC_FIELD_BIT];
    assign h_polarity = sync_q[`SSM_SYNC_H_BIT];
    assign v_polarity = sync_q[`SSM_SYNC_V_BIT];

endmodule : ssm_sfr_space
`default_nettype wire

// File: testbench/sfr_space_map_decode_bench.sv
`timescale 1ns/1ns
`default_nettype none

module sfr_space_map_decode_bench;
    logic sys_clk;
    logic rstn;
    logic [7:0] gpf_in;
    logic sync_525;
    logic signal_quality_flag;
    logic acc_direct, acc_bit, acc_rd, acc_wr, rd_hit;
    logic [7:0] acc_addr, acc_wdata, rd_data;
    logic [8:0] ans;
    logic [28:0] row;
    int num_errors;
    int cmp_count;

    // Row: flags {rd, wr, bit, direct}, address, write data, answer {hit, data}
    localparam int N_ROWS = 40;
    localparam logic [28:0] ROWS [N_ROWS] = '{
        {4'h9, 8'h96, 8'h00, 9'h1FF}, {4'h9, 8'h97, 8'h00, 9'h100},
        {4'h9, 8'hBE, 8'h00, 9'h1FF}, {4'h9, 8'hBF, 8'h00, 9'h100},
        {4'h9, 8'hB4, 8'h00, 9'h100}, {4'h9, 8'hB5, 8'h00, 9'h102},
        {4'h9, 8'hC4, 8'h00, 9'h100}, {4'h9, 8'hC1, 8'h00, 9'h100},
        {4'h9, 8'hD3, 8'h00, 9'h140}, {4'h5, 8'hC4, 8'h5A, 9'h000},
        {4'h9, 8'hC4, 8'h00, 9'h15A}, {4'h5, 8'hC1, 8'hFF, 9'h000},
        {4'h9, 8'hC1, 8'h00, 9'h107}, {4'h5, 8'hB4, 8'hFF, 9'h000},
        {4'h9, 8'hB4, 8'h00, 9'h1CF}, {4'h5, 8'hB5, 8'hA5, 9'h000},
        {4'h9, 8'hB5, 8'h00, 9'h1A5}, {4'h4, 8'hC4, 8'h00, 9'h000},
        {4'h8, 8'hC4, 8'h00, 9'h000}, {4'h9, 8'hC4, 8'h00, 9'h15A},
        {4'h5, 8'h16, 8'h77, 9'h000}, {4'h9, 8'h16, 8'h00, 9'h000},
        {4'h7, 8'hAD, 8'h01, 9'h000}, {4'h9, 8'hA8, 8'h00, 9'h120},
        {4'hB, 8'hAD, 8'h00, 9'h101}, {4'hB, 8'hAC, 8'h00, 9'h100},
        {4'hB, 8'h82, 8'h00, 9'h101}, {4'h7, 8'hC3, 8'h01, 9'h000},
        {4'h9, 8'hC0, 8'h00, 9'h100}, {4'h9, 8'hCC, 8'h00, 9'h1AA},
        {4'h5, 8'hCC, 8'h00, 9'h000}, {4'h9, 8'hCC, 8'h00, 9'h1AA},
        {4'h9, 8'hB6, 8'h00, 9'h13C}, {4'h5, 8'hB6, 8'h00, 9'h000},
        {4'h9, 8'hB6, 8'h00, 9'h13C}, {4'hD, 8'hC4, 8'h33, 9'h15A},
        {4'h9, 8'hC4, 8'h00, 9'h133}, {4'h5, 8'hD3, 8'h00, 9'h000},
        {4'h9, 8'hD3, 8'h00, 9'h140}, {4'h9, 8'h84, 8'h00, 9'h000}
    };

    ssm_sfr_space #(.ROM_VERSION(5'h0A)) u_ssm_sfr_space (
        .sys_clk(sys_clk), .rstn(rstn), .acc_direct(acc_direct), .acc_bit(acc_bit),
        .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .gpf_in(gpf_in), .sync_525(sync_525), .signal_quality_flag(signal_quality_flag),
        .rd_data(rd_data), .rd_hit(rd_hit), .port0_config_a(), .port0_config_b(),
        .port1_config_a(), .port1_config_b(), .port2_config_a(), .port2_config_b(),
        .port3_config_a(), .port3_config_b(), .language_sel(), .language_enable(),
        .planes_bit(), .redefinable_char_enable(), .display_feature_enable(),
        .display_line_count(), .character_size(), .bus_port1_select(),
        .bus_port0_select(), .caption_enable(), .caption_or_teletext_mode(),
        .field_polarity(), .h_polarity(), .v_polarity()
    );

    ssm_core_model u_ssm_core_model (
        .sys_clk(sys_clk), .rd_data(rd_data), .rd_hit(rd_hit), .acc_direct(acc_direct),
        .acc_bit(acc_bit), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic check(input logic [8:0] got, input logic [8:0] exp, input int tag_no);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: step %0d got %h want %h", $time, tag_no, got, exp);
        end
    endtask : check

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // Hang guard: the whole sequence needs well under this many cycles
    initial begin
        repeat (2000) @(posedge sys_clk);
        num_errors++;
        close_out();
    end

    // Main sequence, all inputs moved on falling edges
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        gpf_in = 8'h3C;
        sync_525 = 1'b1;
        signal_quality_flag = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        for (int i = 0; i < N_ROWS; i++) begin
            row = ROWS[i];
            u_ssm_core_model.acc(row[28:25], row[24:17], row[16:9], ans);
            check(ans, row[8:0], i);
        end
        // Status inputs flipped: the answer must follow them
        sync_525 = 1'b0;
        signal_quality_flag = 1'b1;
        u_ssm_core_model.acc(4'h9, 8'hCC, 8'h00, ans);
        check(ans, 9'h12B, 100);
        // Reset in mid-run restores reset values
        u_ssm_core_model.acc(4'h5, 8'h96, 8'h00, ans);
        u_ssm_core_model.idle();
        rstn = 1'b0;
        @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        u_ssm_core_model.acc(4'h9, 8'h96, 8'h00, ans);
        check(ans, 9'h1FF, 101);
        u_ssm_core_model.acc(4'h9, 8'hC4, 8'h00, ans);
        check(ans, 9'h100, 102);
        u_ssm_core_model.idle();
        close_out();
    end
endmodule : sfr_space_map_decode_bench

`default_nettype wire

// File: testbench/ssm_core_model.sv
`timescale 1ns/1ns
`default_nettype none

module ssm_core_model (
    input wire logic sys_clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_hit,
    output logic acc_direct,
    output logic acc_bit,
    output logic acc_rd,
    output logic acc_wr,
    output logic [7:0] acc_addr,
    output logic [7:0] acc_wdata
);
    // Released bus inverts, so a stale value can never pass as held
    task automatic idle();
        {acc_rd, acc_wr, acc_bit, acc_direct} = 4'h0;
        acc_addr = ~acc_addr;
        acc_wdata = ~acc_wdata;
    endtask : idle

    // Entered at a falling edge; request stays up so calls run back to back
    task automatic acc(input logic [3:0] f, input logic [7:0] a, input logic [7:0] d,
                       output logic [8:0] ans);
        {acc_rd, acc_wr, acc_bit, acc_direct} = f;
        acc_addr = a;
        acc_wdata = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        ans = {rd_hit, rd_data};
    endtask : acc

    initial begin
        {acc_rd, acc_wr, acc_bit, acc_direct} = 4'h0;
        acc_addr = 8'h00;
        acc_wdata = 8'h00;
    end
endmodule : ssm_core_model

`default_nettype wire

// File: testbench/ssm_sfr_space_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module ssm_sfr_space_asserts (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic acc_direct,
    input wire logic acc_bit,
    input wire logic acc_rd,
    input wire logic acc_wr,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic sync_525,
    input wire logic signal_quality_flag,
    input wire logic [7:0] rd_data,
    input wire logic rd_hit,
    input wire logic [7:0] port0_config_a,
    input wire logic [7:0] port0_config_b,
    input wire logic [2:0] language_sel,
    input wire logic language_enable,
    input wire logic planes_bit,
    input wire logic redefinable_char_enable,
    input wire logic [7:0] display_feature_enable,
    input wire logic [1:0] display_line_count,
    input wire logic [1:0] character_size,
    input wire logic bus_port1_select,
    input wire logic caption_enable,
    input wire logic bus_port0_select,
    input wire logic caption_or_teletext_mode,
    input wire logic field_polarity,
    input wire logic h_polarity,
    input wire logic v_polarity
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Whole-byte direct write; bit writes would touch other registers
    logic byte_wr;
    assign byte_wr = acc_wr && acc_direct && !acc_bit;

    property p_indirect;
        acc_rd && !acc_direct |=> !rd_hit && rd_data == 8'h00;
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect read answered");
    property p_no_wr_indirect;
        acc_wr && !acc_direct |=> $stable(display_feature_enable);
    endproperty
    a_no_wr_indirect: assert property (p_no_wr_indirect) else $error("indirect write landed");
    property p_hit_cause;
        rd_hit |-> $past(acc_rd) && $past(acc_direct) && $past(acc_addr) >= 8'h80;
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without a valid read");
    property p_low;
        acc_rd && acc_direct && !acc_addr[7] |=> rd_data == 8'h00;
    endproperty
    a_low: assert property (p_low) else $error("lower memory read as register");
    property p_bit_rd;
        acc_rd && acc_direct && acc_bit |=> rd_data[7:1] == 7'h00;
    endproperty
    a_bit_rd: assert property (p_bit_rd) else $error("bit read upper bits set");
    property p_video;
        acc_rd && acc_direct && !acc_bit && acc_addr == 8'hCC |=> rd_hit && rd_data[1]
            && rd_data[7] == $past(sync_525) && rd_data[0] == $past(signal_quality_flag);
    endproperty
    a_video: assert property (p_video) else $error("video status wrong");
    property p_feat;
        byte_wr && acc_addr == 8'hC4 |=> display_feature_enable == $past(acc_wdata);
    endproperty
    a_feat: assert property (p_feat) else $error("feature enables not written");
    property p_lang;
        byte_wr && acc_addr == 8'hB4 |=> ($past(acc_wdata) & 8'hCF) ==
            {redefinable_char_enable, planes_bit, 2'h0, language_enable, language_sel};
    endproperty
    a_lang: assert property (p_lang) else $error("language fields wrong");
    property p_sync;
        byte_wr && acc_addr == 8'hC1 |=>
            {5'h00, field_polarity, h_polarity, v_polarity} == ($past(acc_wdata) & 8'h07);
    endproperty
    a_sync: assert property (p_sync) else $error("sync polarity wrong");
    property p_size;
        byte_wr && acc_addr == 8'hB5 |=> $past(acc_wdata) == {display_line_count,
            character_size, bus_port1_select, caption_enable, bus_port0_select,
            caption_or_teletext_mode};
    endproperty
    a_size: assert property (p_size) else $error("size fields wrong");
    property p_reset;
        $rose(rstn) |-> port0_config_a == 8'hFF && port0_config_b == 8'h00
            && display_feature_enable == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    c_bit_rd: cover property (acc_rd && acc_bit && acc_direct ##1 rd_hit);
    c_video: cover property (acc_rd && acc_direct && acc_addr == 8'hCC ##1 rd_hit);
    c_reset: cover property ($rose(rstn));
endmodule : ssm_sfr_space_asserts

bind ssm_sfr_space ssm_sfr_space_asserts u_ssm_sfr_space_asserts (
    .sys_clk(sys_clk), .rstn(rstn), .acc_direct(acc_direct), .acc_bit(acc_bit),
    .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .sync_525(sync_525), .signal_quality_flag(signal_quality_flag),
    .rd_data(rd_data), .rd_hit(rd_hit), .port0_config_a(port0_config_a),
    .port0_config_b(port0_config_b), .language_sel(language_sel),
    .language_enable(language_enable), .planes_bit(planes_bit),
    .redefinable_char_enable(redefinable_char_enable),
    .display_feature_enable(display_feature_enable), .field_polarity(field_polarity),
    .h_polarity(h_polarity), .v_polarity(v_polarity),
    .display_line_count(display_line_count), .character_size(character_size),
    .bus_port1_select(bus_port1_select), .caption_enable(caption_enable),
    .bus_port0_select(bus_port0_select),
    .caption_or_teletext_mode(caption_or_teletext_mode)
);

`default_nettype wire
